// file: bench/color_source.sv
// projector timing controller model driving the color enables and the pwm level
module color_source (
    input wire logic clock,
    output logic [2:0] color_en,
    output logic pwm_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        color_en = 3'h0;
        pwm_in = 1'b0;
    end

    // ===========================================================
    // enable sequencing, all timing comes from this side
    task automatic set_colors(input logic [2:0] v);
        @(posedge clock);
        color_en <= v;
    endtask

    // pwm level changes land just after an edge, settle time is the caller's choice
    task automatic set_pwm(input logic v);
        @(posedge clock);
        pwm_in <= v;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
endmodule

// file: bench/test_sequential_led_mode_and_enable_arbiter.sv
// self-checking bench for the led mode sequencer and enable arbiter
module test_sequential_led_mode_and_enable_arbiter;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic sys_rst;
    logic global_en;
    logic por;
    logic thermal_shutdown;
    logic [2:0] color_en;
    logic pwm_in;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_rdata;
    logic [2:0] driver_on;
    logic converter_on, converter_low_current, support_on, nvm_prog, bright_pwm_level;
    logic [5:0] mode_state;
    logic [1:0] bright_src;
    logic [31:0] rd;
    int err_total = 0;
    int comparisons = 0;

    always #5 clock = ~clock;

    led_seq_ctrl #(.TIMER_WIDTH(24), .PWM_SETTLE(24'h000014)) dut (
        .clock(clock), .sys_rst(sys_rst), .global_en(global_en), .por(por),
        .thermal_shutdown(thermal_shutdown), .color_en(color_en), .pwm_in(pwm_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .driver_on(driver_on), .converter_on(converter_on),
        .converter_low_current(converter_low_current), .support_on(support_on),
        .nvm_prog(nvm_prog), .mode_state(mode_state), .bright_src(bright_src),
        .bright_pwm_level(bright_pwm_level)
    );

    color_source src (.clock(clock), .color_en(color_en), .pwm_in(pwm_in));

    // ===========================================================
    // shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic wait_mode(input logic [5:0] m, input int n);
        int i;
        i = 0;
        while (mode_state !== m && i < n)
        begin
            @(posedge clock);
            #1;
            i++;
        end
        check(32'(mode_state), 32'(m));
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic complete_run;
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ===========================================================
    // scenarios
    task automatic startup_to_standby;
        check(32'(mode_state), 32'(led_seq_pkg::MODE_SHUTDOWN));
        wait_mode(led_seq_pkg::MODE_STANDBY, 60);
        check(32'({support_on, converter_on, driver_on}), 32'h00000010);
        reg_rd(led_seq_pkg::ADDR_CTRL);
        check(rd, 32'(led_seq_pkg::CTRL_RESET));
        reg_rd(led_seq_pkg::ADDR_FADER);
        check(rd, 32'(led_seq_pkg::FADER_RESET));
    endtask

    task automatic standby_registers;
        reg_wr(led_seq_pkg::ADDR_CTRL, 32'h2);
        settle(1);
        check(32'(bright_src), 32'(led_seq_pkg::BRIGHT_FADER));
        reg_wr(led_seq_pkg::ADDR_CTRL, 32'h0);
        settle(1);
        check(32'(bright_src), 32'(led_seq_pkg::BRIGHT_NONE));
        reg_wr(led_seq_pkg::ADDR_CTRL, 32'h3);
        settle(1);
        check(32'(bright_src), 32'(led_seq_pkg::BRIGHT_PWM));
        reg_wr(led_seq_pkg::ADDR_CTRL, 32'h1);
        reg_wr(led_seq_pkg::ADDR_SOFT_START, 32'h5);
        reg_wr(led_seq_pkg::ADDR_TIMEOUT, 32'hC);
        reg_rd(led_seq_pkg::ADDR_SOFT_START);
        check(rd, 32'h00000005);
        reg_rd(4'hF);
        check(rd, 32'h0);
        reg_wr(led_seq_pkg::ADDR_NVM_CMD, 32'h1);
        settle(2);
        check(32'(nvm_prog), 32'h1);
        reg_wr(led_seq_pkg::ADDR_NVM_CMD, 32'h0);
        settle(2);
        check(32'(nvm_prog), 32'h0);
    endtask

    task automatic soft_start_to_normal;
        src.set_pwm(1'b1);
        src.idle(25);
        src.set_colors(3'h1);
        wait_mode(led_seq_pkg::MODE_SOFT_START, 4);
        check(32'({converter_low_current, driver_on}), 32'h00000008);
        wait_mode(led_seq_pkg::MODE_NORMAL, 20);
        settle(4);
        check(32'({converter_on, driver_on}), 32'h00000009);
        check(32'(bright_pwm_level), 32'h1);
        reg_wr(led_seq_pkg::ADDR_NVM_CMD, 32'h1);
        settle(2);
        check(32'(nvm_prog), 32'h0);
    endtask

    task automatic arbitration;
        src.set_pwm(1'b0);
        src.set_colors(3'h3);
        settle(4);
        check(32'(driver_on), 32'h1);
        src.set_colors(3'h2);
        settle(4);
        check(32'(driver_on), 32'h2);
        check(32'(bright_pwm_level), 32'h1);
        src.set_colors(3'h7);
        settle(25);
        check(32'(driver_on), 32'h2);
        src.set_colors(3'h5);
        settle(4);
        check(32'(driver_on), 32'h1);
        check(32'(bright_pwm_level), 32'h0);
        src.set_colors(3'h4);
        settle(4);
        check(32'(driver_on), 32'h4);
        reg_rd(led_seq_pkg::ADDR_STATUS);
        check(rd, 32'h00000110);
        reg_rd(led_seq_pkg::ADDR_BRIGHT);
        check(rd, 32'h00000001);
        src.set_colors(3'h0);
        settle(4);
        check(32'(driver_on), 32'h0);
    endtask

    task automatic idle_timeout;
        settle(6);
        check(32'(mode_state), 32'(led_seq_pkg::MODE_NORMAL));
        src.set_colors(3'h1);
        src.set_colors(3'h0);
        settle(9);
        check(32'(mode_state), 32'(led_seq_pkg::MODE_NORMAL));
        wait_mode(led_seq_pkg::MODE_STANDBY, 20);
        check(32'({converter_on, driver_on}), 32'h00000000);
    endtask

    task automatic over_temperature;
        src.set_colors(3'h2);
        wait_mode(led_seq_pkg::MODE_NORMAL, 30);
        @(posedge clock);
        thermal_shutdown <= 1'b1;
        wait_mode(led_seq_pkg::MODE_THERMAL, 5);
        check(32'({converter_on, driver_on}), 32'h00000000);
        src.set_colors(3'h0);
        settle(6);
        check(32'(mode_state), 32'(led_seq_pkg::MODE_THERMAL));
        @(posedge clock);
        thermal_shutdown <= 1'b0;
        wait_mode(led_seq_pkg::MODE_STANDBY, 6);
    endtask

    task automatic shutdown_paths;
        @(posedge clock);
        global_en <= 1'b0;
        wait_mode(led_seq_pkg::MODE_SHUTDOWN, 5);
        check(32'({support_on, converter_on, driver_on}), 32'h00000000);
        @(posedge clock);
        global_en <= 1'b1;
        wait_mode(led_seq_pkg::MODE_STANDBY, 60);
        reg_rd(led_seq_pkg::ADDR_TIMEOUT);
        check(rd, 32'(led_seq_pkg::TIMEOUT_RESET));
        @(posedge clock);
        por <= 1'b1;
        wait_mode(led_seq_pkg::MODE_SHUTDOWN, 5);
        check(32'(support_on), 32'h0);
    endtask

    // ===========================================================
    // main sequence and watchdog
    initial
    begin
        sys_rst = 1'b1;
        global_en = 1'b1;
        por = 1'b0;
        thermal_shutdown = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h00000000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        settle(1);
        startup_to_standby();
        standby_registers();
        soft_start_to_normal();
        arbitration();
        idle_timeout();
        over_temperature();
        shutdown_paths();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end
endmodule

// file: design/color_grant.sv
// one-hot grant of a single led driver with red-green-blue priority
module color_grant (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic allow,
    input wire logic [2:0] color_en,
    output logic [2:0] grant,
    output logic grant_rise
);
    logic [2:0] prio;
    logic held;
    logic [2:0] next_grant;

    // bit 0 red, 1 green, 2 blue; lowest index wins
    assign prio = color_en[0] ? 3'h1 : color_en[1] ? 3'h2 : color_en[2] ? 3'h4 : 3'h0;
    assign held = |(grant & color_en);
    assign next_grant = !allow ? 3'h0 : held ? grant : prio;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            grant <= 3'h0;
            grant_rise <= 1'b0;
        end
        else
        begin
            grant <= next_grant;
            grant_rise <= (next_grant != 3'h0) && (next_grant != grant);
        end
    end

    chk_grant_onehot: assert property (@(posedge clock) disable iff (sys_rst) $onehot0(grant))
        else $error("more than one driver granted");
    chk_grant_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (allow && grant != 3'h0 && $past(allow) && |(grant & color_en)) |=> grant == $past(grant))
        else $error("active driver lost its grant while enable high");
endmodule

// file: design/idle_timer.sv
// counter that runs while a condition holds and flags when a limit is reached
module idle_timer #(
    parameter int WIDTH = 24
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic [WIDTH-1:0] limit,
    output logic expired
);
    logic [WIDTH-1:0] count;

    assign expired = !restart && (count >= limit);

    always_ff @(posedge clock)
    begin
        if (sys_rst || restart)
            count <= '0;
        else if (count < limit)
            count <= count + WIDTH'(1);
    end
endmodule

// file: design/led_seq_ctrl.sv
// operating mode sequencer and color enable arbiter of the sequential led driver
// Function
// - shutdown with all disabled whenever global enable low or power-on reset.
// - on enable high, start support blocks and load nonvolatile settings.
// - after startup go to standby, converter and drivers off.
// - control register writes in standby take effect at once.
// - nonvolatile programming only in standby; controller must not ask otherwise.
// - any color enable in standby starts soft-start for programmed duration.
// - normal mode: converter active, drivers follow color enables directly.
// - all enables low for timeout period returns normal to standby.
// - over-temperature forces standby until the condition clears.
// - one driver at a time; a new color waits for active one to fall.
// - pending colors are granted red first, then green, then blue.
// - driver timing follows only the enable inputs, nothing internal.
// - brightness change applies at next enable rise after timeout elapsed.
// - brightness source: none, fader if only fader bit, otherwise pwm.
//
// The implementer's own choices: the address-and-strobe port and the address map.
module led_seq_ctrl #(
    parameter int TIMER_WIDTH = 24,
    parameter logic [TIMER_WIDTH-1:0] PWM_SETTLE = TIMER_WIDTH'(led_seq_pkg::TIMEOUT_CYCLES)
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic global_en,
    input wire logic por,
    input wire logic thermal_shutdown,
    input wire logic [2:0] color_en,
    input wire logic pwm_in,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic [2:0] driver_on,
    output logic converter_on,
    output logic converter_low_current,
    output logic support_on,
    output logic nvm_prog,
    output logic [5:0] mode_state,
    output logic [1:0] bright_src,
    output logic bright_pwm_level
);
    // ===========================================================
    // state
    led_seq_pkg::mode_t mode;
    led_seq_pkg::mode_t next_mode;
    logic [7:0] ctrl;
    logic [TIMER_WIDTH-1:0] soft_start_len;
    logic [TIMER_WIDTH-1:0] timeout_len;
    logic [7:0] fader;
    logic [7:0] startup_count;
    logic nvm_loaded;
    logic [TIMER_WIDTH-1:0] soft_count;
    logic pwm_prev;
    logic [TIMER_WIDTH-1:0] pwm_age;
    logic pwm_pending;
    logic [2:0] grant;
    logic grant_rise;
    logic idle_expired;

    // ===========================================================
    // decode
    wire any_en = |color_en;
    wire kill = !global_en || por;
    wire in_standby = (mode == led_seq_pkg::MODE_STANDBY);
    wire in_normal = (mode == led_seq_pkg::MODE_NORMAL);
    wire in_soft = (mode == led_seq_pkg::MODE_SOFT_START);
    wire in_startup = (mode == led_seq_pkg::MODE_STARTUP);
    wire wr_ctrl = reg_write && reg_addr == led_seq_pkg::ADDR_CTRL;
    wire wr_soft = reg_write && reg_addr == led_seq_pkg::ADDR_SOFT_START;
    wire wr_tout = reg_write && reg_addr == led_seq_pkg::ADDR_TIMEOUT;
    wire wr_fader = reg_write && reg_addr == led_seq_pkg::ADDR_FADER;
    wire wr_nvm = reg_write && reg_addr == led_seq_pkg::ADDR_NVM_CMD;
    wire startup_done = in_startup && nvm_loaded && (startup_count >= 8'(led_seq_pkg::STARTUP_CYCLES));
    wire soft_done = in_soft && (soft_count >= soft_start_len);
    wire pwm_sel = ctrl[led_seq_pkg::CTRL_PWM_BIT];
    wire fad_sel = ctrl[led_seq_pkg::CTRL_FADER_BIT];
    wire [1:0] next_src = pwm_sel ? led_seq_pkg::BRIGHT_PWM
        : fad_sel ? led_seq_pkg::BRIGHT_FADER : led_seq_pkg::BRIGHT_NONE;
    wire pwm_ready = pwm_pending && (pwm_age >= PWM_SETTLE);

    // ===========================================================
    // mode sequencer
    always_comb
    begin
        next_mode = mode;
        if (kill)
            next_mode = led_seq_pkg::MODE_SHUTDOWN;
        else
        begin
            unique case (mode)
                led_seq_pkg::MODE_SHUTDOWN:
                    next_mode = led_seq_pkg::MODE_STARTUP;
                led_seq_pkg::MODE_STARTUP:
                    if (startup_done)
                        next_mode = led_seq_pkg::MODE_STANDBY;
                led_seq_pkg::MODE_STANDBY:
                    if (thermal_shutdown)
                        next_mode = led_seq_pkg::MODE_THERMAL;
                    else if (any_en)
                        next_mode = led_seq_pkg::MODE_SOFT_START;
                led_seq_pkg::MODE_SOFT_START:
                    if (thermal_shutdown)
                        next_mode = led_seq_pkg::MODE_THERMAL;
                    else if (soft_done)
                        next_mode = led_seq_pkg::MODE_NORMAL;
                led_seq_pkg::MODE_NORMAL:
                    if (thermal_shutdown)
                        next_mode = led_seq_pkg::MODE_THERMAL;
                    else if (idle_expired)
                        next_mode = led_seq_pkg::MODE_STANDBY;
                led_seq_pkg::MODE_THERMAL:
                    if (!thermal_shutdown)
                        next_mode = led_seq_pkg::MODE_STANDBY;
                default:
                    next_mode = led_seq_pkg::MODE_SHUTDOWN;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            mode <= led_seq_pkg::MODE_SHUTDOWN;
        else
            mode <= next_mode;
    end

    // ===========================================================
    // startup sequence: support warm-up and nonvolatile image load
    always_ff @(posedge clock)
    begin
        if (sys_rst || !in_startup)
        begin
            startup_count <= 8'h00;
            nvm_loaded <= 1'b0;
        end
        else
        begin
            if (startup_count < 8'(led_seq_pkg::NVM_LOAD_CYCLES))
                startup_count <= startup_count + 8'h01;
            nvm_loaded <= 1'b1;
        end
    end

    // ===========================================================
    // control registers, written any time outside startup, effective at once
    always_ff @(posedge clock)
    begin
        if (sys_rst || in_startup)
        begin
            ctrl <= led_seq_pkg::CTRL_RESET;
            soft_start_len <= TIMER_WIDTH'(led_seq_pkg::SOFT_START_RESET);
            timeout_len <= TIMER_WIDTH'(led_seq_pkg::TIMEOUT_RESET);
            fader <= led_seq_pkg::FADER_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= reg_wdata[7:0];
            if (wr_soft)
                soft_start_len <= reg_wdata[TIMER_WIDTH-1:0];
            if (wr_tout)
                timeout_len <= reg_wdata[TIMER_WIDTH-1:0];
            if (wr_fader)
                fader <= reg_wdata[7:0];
        end
    end

    // ===========================================================
    // nonvolatile programming request, honoured in standby only
    always_ff @(posedge clock)
    begin
        if (sys_rst || !in_standby)
            nvm_prog <= 1'b0;
        else if (wr_nvm)
            nvm_prog <= reg_wdata[0];
    end

    // ===========================================================
    // soft-start timer
    always_ff @(posedge clock)
    begin
        if (sys_rst || !in_soft)
            soft_count <= '0;
        else if (soft_count < soft_start_len)
            soft_count <= soft_count + TIMER_WIDTH'(1);
    end

    // ===========================================================
    // idle timer back to standby
    idle_timer #(
        .WIDTH(TIMER_WIDTH)
    ) u_idle (
        .clock(clock),
        .sys_rst(sys_rst),
        .restart(any_en || !in_normal),
        .limit(timeout_len),
        .expired(idle_expired)
    );

    // ===========================================================
    // driver arbitration
    color_grant u_grant (
        .clock(clock),
        .sys_rst(sys_rst),
        .allow(in_normal && next_mode == led_seq_pkg::MODE_NORMAL),
        .color_en(color_en),
        .grant(grant),
        .grant_rise(grant_rise)
    );

    // ===========================================================
    // brightness: pwm level latched at driver start once settled
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pwm_prev <= 1'b0;
            pwm_age <= '0;
            pwm_pending <= 1'b0;
            bright_pwm_level <= 1'b0;
        end
        else
        begin
            pwm_prev <= pwm_in;
            if (pwm_in != pwm_prev)
            begin
                pwm_age <= '0;
                pwm_pending <= 1'b1;
            end
            else
            begin
                if (pwm_age < PWM_SETTLE)
                    pwm_age <= pwm_age + TIMER_WIDTH'(1);
                if (grant_rise && pwm_ready)
                    pwm_pending <= 1'b0;
            end
            if (grant_rise && pwm_ready)
                bright_pwm_level <= pwm_prev;
        end
    end

    // ===========================================================
    // outputs and register read
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            driver_on <= 3'h0;
            converter_on <= 1'b0;
            converter_low_current <= 1'b0;
            support_on <= 1'b0;
            mode_state <= 6'h01;
            bright_src <= led_seq_pkg::BRIGHT_NONE;
            reg_rdata <= 32'h00000000;
        end
        else
        begin
            driver_on <= grant;
            converter_on <= in_soft || in_normal;
            converter_low_current <= in_soft;
            support_on <= !kill && (mode != led_seq_pkg::MODE_SHUTDOWN);
            mode_state <= mode;
            bright_src <= next_src;
            reg_rdata <= 32'h00000000;
            if (reg_read)
            begin
                unique case (reg_addr)
                    led_seq_pkg::ADDR_CTRL: reg_rdata <= {24'h000000, ctrl};
                    led_seq_pkg::ADDR_SOFT_START: reg_rdata <= 32'(soft_start_len);
                    led_seq_pkg::ADDR_TIMEOUT: reg_rdata <= 32'(timeout_len);
                    led_seq_pkg::ADDR_FADER: reg_rdata <= {24'h000000, fader};
                    led_seq_pkg::ADDR_STATUS: reg_rdata <= {22'h000000, thermal_shutdown, grant, 6'(mode)};
                    led_seq_pkg::ADDR_NVM_CMD: reg_rdata <= {31'h00000000, nvm_prog};
                    led_seq_pkg::ADDR_BRIGHT: reg_rdata <= {29'h00000000, bright_pwm_level, next_src};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ===========================================================
    // checks: mode sequencing
    chk_kill_shutdown: assert property (@(posedge clock) disable iff (sys_rst)
        kill |=> mode == led_seq_pkg::MODE_SHUTDOWN ##1 driver_on == 3'h0)
        else $error("enable low did not reach shutdown");
    chk_shutdown_exit: assert property (@(posedge clock) disable iff (sys_rst)
        (mode == led_seq_pkg::MODE_SHUTDOWN && !kill) |=> in_startup)
        else $error("enable high did not start the startup sequence");
    chk_startup_standby: assert property (@(posedge clock) disable iff (sys_rst)
        (startup_done && !kill) |=> in_standby)
        else $error("startup did not end in standby");
    chk_standby_drivers_off: assert property (@(posedge clock) disable iff (sys_rst)
        (in_standby && $past(in_standby)) |=> driver_on == 3'h0 && !converter_on)
        else $error("driver active in standby");
    chk_standby_to_soft: assert property (@(posedge clock) disable iff (sys_rst)
        (in_standby && any_en && !kill && !thermal_shutdown) |=> in_soft)
        else $error("enable in standby did not start soft-start");
    chk_soft_low_current: assert property (@(posedge clock) disable iff (sys_rst)
        in_soft |=> converter_low_current && converter_on)
        else $error("soft-start without low-current converter");
    chk_soft_exit: assert property (@(posedge clock) disable iff (sys_rst)
        (soft_done && !kill && !thermal_shutdown) |=> in_normal)
        else $error("soft-start expiry did not enter normal mode");
    chk_thermal_leaves: assert property (@(posedge clock) disable iff (sys_rst)
        (in_normal && thermal_shutdown && !kill) |=> mode == led_seq_pkg::MODE_THERMAL ##1 driver_on == 3'h0)
        else $error("thermal event did not stop operation");
    chk_thermal_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (mode == led_seq_pkg::MODE_THERMAL && thermal_shutdown && !kill) |=> mode == led_seq_pkg::MODE_THERMAL)
        else $error("left thermal fallback while the condition stood");
    chk_idle_expiry: assert property (@(posedge clock) disable iff (sys_rst)
        (in_normal && idle_expired && !thermal_shutdown && !kill) |=> in_standby)
        else $error("idle timeout did not return to standby");
    chk_idle_return: assert property (@(posedge clock) disable iff (sys_rst)
        (in_normal && any_en && !kill && !thermal_shutdown) |=> in_normal)
        else $error("left normal mode while an enable was high");
    chk_nvm_standby: assert property (@(posedge clock) disable iff (sys_rst)
        nvm_prog |-> $past(in_standby))
        else $error("nonvolatile programming outside standby");
    chk_nvm_cleared: assert property (@(posedge clock) disable iff (sys_rst)
        !in_standby |=> !nvm_prog)
        else $error("nonvolatile programming kept after standby");
    chk_ctrl_write: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_ctrl && !in_startup) |=> ##1 bright_src == ($past(reg_wdata[0], 2) ? led_seq_pkg::BRIGHT_PWM
            : $past(reg_wdata[1], 2) ? led_seq_pkg::BRIGHT_FADER : led_seq_pkg::BRIGHT_NONE))
        else $error("control write did not take effect");

    // ===========================================================
    // checks: drivers and brightness
    chk_drivers_need_normal: assert property (@(posedge clock) disable iff (sys_rst)
        !in_normal |-> ##2 driver_on == 3'h0)
        else $error("driver active outside normal mode");
    chk_driver_onehot: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot0(driver_on))
        else $error("more than one driver output on");
    chk_driver_enable: assert property (@(posedge clock) disable iff (sys_rst)
        (driver_on != 3'h0) |-> (driver_on & $past(color_en, 2)) != 3'h0)
        else $error("driver on without its color enable");
    chk_bright_at_grant: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(bright_pwm_level) |-> $past(grant_rise))
        else $error("brightness level changed away from a grant start");
endmodule

// file: design/led_seq_pkg.sv
// shared constants for the sequential led mode and enable arbiter
package led_seq_pkg;
    // ===========================================================
    // clock and timing
    localparam int CLOCK_MHZ = 100;
    localparam int TIMEOUT_US = 300;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLOCK_MHZ;
    localparam int NVM_LOAD_CYCLES = 16;
    localparam int STARTUP_CYCLES = 8;

    // ===========================================================
    // register map, word index on the plain port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SOFT_START = 4'h1;
    localparam logic [3:0] ADDR_TIMEOUT = 4'h2;
    localparam logic [3:0] ADDR_FADER = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_NVM_CMD = 4'h5;
    localparam logic [3:0] ADDR_BRIGHT = 4'h6;

    // ===========================================================
    // control fields
    localparam int CTRL_PWM_BIT = 0;
    localparam int CTRL_FADER_BIT = 1;

    // ===========================================================
    // reset values, also the defaults held in the nonvolatile image
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [23:0] SOFT_START_RESET = 24'h0003E8;
    localparam logic [23:0] TIMEOUT_RESET = 24'h007530;
    localparam logic [7:0] FADER_RESET = 8'hFF;

    // ===========================================================
    // brightness source select
    localparam logic [1:0] BRIGHT_NONE = 2'h0;
    localparam logic [1:0] BRIGHT_PWM = 2'h1;
    localparam logic [1:0] BRIGHT_FADER = 2'h2;

    typedef enum logic [5:0] {
        MODE_SHUTDOWN = 6'h01,
        MODE_STARTUP = 6'h02,
        MODE_STANDBY = 6'h04,
        MODE_SOFT_START = 6'h08,
        MODE_NORMAL = 6'h10,
        MODE_THERMAL = 6'h20
    } mode_t;
endpackage
